// File: src/eeprom_calib_pkg.sv
// Constants and carriers for the calibration loader and interpolation engine.
// Assumes one 200 MHz system clock; the memory link is sampled from it.
package eeprom_calib_pkg;

  // Setup section layout, in 16-bit word indices
  localparam int unsigned SETUP_BYTES = 16;
  localparam logic [6:0] W_MARKER = 7'h00;
  localparam logic [6:0] W_USER_A = 7'h01;
  localparam logic [6:0] W_USER_B = 7'h02;
  localparam logic [6:0] W_CFG3 = 7'h03;
  localparam logic [6:0] W_CFG4 = 7'h04;
  localparam logic [6:0] W_CFG5 = 7'h05;
  localparam logic [6:0] W_CFG6 = 7'h06;
  localparam logic [6:0] W_SETUP_CS = 7'h07;

  // Table entry slots: index, zero word, gain word
  localparam logic [1:0] SLOT_INDEX = 2'h0;
  localparam logic [1:0] SLOT_ZERO = 2'h1;
  localparam logic [1:0] SLOT_GAIN = 2'h2;

  localparam logic [15:0] TABLE_END_INDEX = 16'h7fff;
  localparam logic [15:0] CHECKSUM_TARGET = 16'hffff;
  localparam int unsigned SLOPE_FRAC_BITS = 8;
  localparam int unsigned MAX_TABLE_INDICES = 17;

  // Temperature converter control: bit that selects unsigned index format
  localparam int unsigned CFG6_UNSIGNED_BIT = 0;

  // Reset values
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] DAC_RESET = 16'h0000;

  typedef struct packed {
    logic [15:0] ref_lin;
    logic [15:0] coarse_gain;
    logic [15:0] fe_limits;
    logic [15:0] temp_ctrl;
  } cfg_regs_s;

  typedef struct packed {
    logic marker_bad;
    logic setup_cs_bad;
    logic table_cs_bad;
    logic table_overrun;
  } load_err_s;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_SETUP,
    PH_TABLE,
    PH_DONE
  } phase_e;

endpackage

// File: src/eeprom_calib_lookup_interp.sv
// Calibration loader: reads the serial memory after each idle conversion, or the last one during a pass, and interpolates the DACs.
// Assumes the memory streams bytes from address 0, MSB first, on each rising link clock edge
// while the read request is high.
//
// Functional notes
// - First 16 bytes form the setup section
// - Spare words summed but never loaded
// - Words 3..6 load configuration registers 3..6
// - Setup words plus checksum must sum FFFF
// - First entry gives start index, zero, gain
// - At most 17 indices before the terminator
// - Table words plus checksum must sum FFFF
// - Index 7FFF ends table; gain word checksum
// - Reading at/below first index uses start values
// - Slopes signed, scaled by 256, removed
// - Each idle conversion, or the last one during a pass, starts a memory read from address 0
// - Accumulators start at start zero/gain values
// - Passed entries add slope times index step
// - First higher index adds partial step, done
// - Keep reading to table end after found
// - Zero setting interpolated alongside gain
// - Index compare follows converter format bit
`timescale 1ns/1ps
module eeprom_calib_lookup_interp
  import eeprom_calib_pkg::*;
#(
  parameter logic [15:0] MARKER_WORD = 16'ha5c3, // Arbitrary programmed-marker value
  parameter int unsigned MAX_INDICES = MAX_TABLE_INDICES
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic conv_done_i,
  input wire logic [15:0] conv_result_i,
  input wire logic link_clk_i,
  input wire logic link_data_i,
  output logic rd_req_o,
  output cfg_regs_s cfg_o,
  output logic [15:0] zero_dac_o,
  output logic [15:0] gain_dac_o,
  output load_err_s load_err_o,
  output logic error_o,
  output logic busy_o,
  output logic update_o
);

  if (MAX_INDICES < 1 || MAX_INDICES > 31) begin : g_param_check
    $error("MAX_INDICES out of range");
  end

  phase_e state_reg, state_next;
  logic lclk_s1_reg, lclk_s2_reg, lclk_s3_reg, ldat_s1_reg, ldat_s2_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] byte_shift_reg, byte_next, high_byte_reg;
  logic odd_byte_reg, bit_tick, byte_done;
  logic word_vld_reg;
  logic [15:0] word_reg, sum_reg, sum_next;
  logic [6:0] word_cnt_reg;
  logic [1:0] slot_reg;
  logic [4:0] entry_cnt_reg;
  logic pend_reg, start;
  logic [15:0] pend_result_reg, reading_reg;
  cfg_regs_s cfg_shadow_reg, cfg_reg;
  logic [15:0] idx_reg, zslope_reg, prev_idx_reg, zero_dac_reg, gain_dac_reg;
  logic found_reg, is_unsigned, idx_above, setup_end, setup_ok, term_end, overrun;
  logic signed [16:0] diff;
  logic signed [32:0] zprod, gprod;
  logic signed [39:0] zacc_reg, gacc_reg;
  load_err_s err_pass_reg, err_reg;
  logic rd_req_reg, busy_reg, update_reg, error_reg, marker_seen_reg;

  // Link synchronisers and edge detect
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      lclk_s1_reg <= 1'b0;
      lclk_s2_reg <= 1'b0;
      lclk_s3_reg <= 1'b0;
      ldat_s1_reg <= 1'b0;
      ldat_s2_reg <= 1'b0;
    end else if (ce_i) begin
      lclk_s1_reg <= link_clk_i;
      lclk_s2_reg <= lclk_s1_reg;
      lclk_s3_reg <= lclk_s2_reg;
      ldat_s1_reg <= link_data_i;
      ldat_s2_reg <= ldat_s1_reg;
    end
  end
  assign bit_tick = ce_i && rd_req_reg && lclk_s2_reg && !lclk_s3_reg;
  assign byte_next = {byte_shift_reg[6:0], ldat_s2_reg};
  assign byte_done = bit_tick && (bit_cnt_reg == 3'd7);
  // Byte and word assembly
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      bit_cnt_reg <= 3'd0;
      byte_shift_reg <= 8'h00;
      high_byte_reg <= 8'h00;
      odd_byte_reg <= 1'b0;
      word_vld_reg <= 1'b0;
      word_reg <= 16'h0000;
    end else if (ce_i) begin
      word_vld_reg <= 1'b0;
      if (state_reg == PH_IDLE) begin
        bit_cnt_reg <= 3'd0;
        odd_byte_reg <= 1'b0;
      end else if (bit_tick) begin
        bit_cnt_reg <= bit_cnt_reg + 3'd1;
        byte_shift_reg <= byte_next;
        if (byte_done) begin
          odd_byte_reg <= !odd_byte_reg;
          if (!odd_byte_reg) begin
            high_byte_reg <= byte_next;
          end else begin
            word_vld_reg <= 1'b1;
            word_reg <= {high_byte_reg, byte_next};
          end
        end
      end
    end
  end

  // Comparison format and step arithmetic
  assign is_unsigned = cfg_shadow_reg.temp_ctrl[CFG6_UNSIGNED_BIT];
  always_comb begin
    logic [15:0] hi;
    hi = 16'h0000;
    if (is_unsigned) begin
      idx_above = (idx_reg > reading_reg);
    end else begin
      idx_above = ($signed(idx_reg) > $signed(reading_reg));
    end
    hi = idx_above ? reading_reg : idx_reg;
    if (is_unsigned) begin
      diff = $signed({1'b0, hi}) - $signed({1'b0, prev_idx_reg});
    end else begin
      diff = $signed({hi[15], hi}) - $signed({prev_idx_reg[15], prev_idx_reg});
    end
  end
  assign zprod = $signed(zslope_reg) * diff;
  assign gprod = $signed(word_reg) * diff;

  assign sum_next = sum_reg + word_reg;
  assign setup_end = word_vld_reg && (state_reg == PH_SETUP) && (word_cnt_reg == W_SETUP_CS);
  assign setup_ok = marker_seen_reg && (sum_next == CHECKSUM_TARGET);
  assign term_end = word_vld_reg && (state_reg == PH_TABLE) && (slot_reg == SLOT_GAIN) &&
                    (idx_reg == TABLE_END_INDEX);
  assign overrun = word_vld_reg && (state_reg == PH_TABLE) && (slot_reg == SLOT_GAIN) &&
                   (idx_reg != TABLE_END_INDEX) && (entry_cnt_reg == 5'(MAX_INDICES));

  assign start = (conv_done_i || pend_reg) && (state_reg == PH_IDLE);
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PH_IDLE: begin
        if (start) state_next = PH_SETUP;
      end
      PH_SETUP: begin
        if (setup_end) state_next = setup_ok ? PH_TABLE : PH_DONE;
      end
      PH_TABLE: begin
        if (term_end || overrun) state_next = PH_DONE;
      end
      default: begin
        state_next = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      state_reg <= PH_IDLE;
      rd_req_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      rd_req_reg <= (state_next == PH_SETUP) || (state_next == PH_TABLE);
      busy_reg <= (state_next != PH_IDLE);
    end
  end

  // Conversion capture; a conversion during a pass waits for the next one
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      pend_reg <= 1'b0;
      pend_result_reg <= 16'h0000;
      reading_reg <= 16'h0000;
    end else if (ce_i) begin
      if (start) begin
        reading_reg <= conv_done_i ? conv_result_i : pend_result_reg;
        pend_reg <= 1'b0;
      end else if (conv_done_i) begin
        pend_reg <= 1'b1;
        pend_result_reg <= conv_result_i;
      end
    end
  end

  // Word counting, checksum sums and setup shadow
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      word_cnt_reg <= 7'd0;
      sum_reg <= 16'h0000;
      marker_seen_reg <= 1'b0;
      cfg_shadow_reg <= '{CFG_RESET, CFG_RESET, CFG_RESET, CFG_RESET};
    end else if (ce_i) begin
      if (state_reg == PH_IDLE) begin
        word_cnt_reg <= 7'd0;
        sum_reg <= 16'h0000;
        marker_seen_reg <= 1'b0;
      end else if (word_vld_reg) begin
        word_cnt_reg <= word_cnt_reg + 7'd1;
        sum_reg <= setup_end ? 16'h0000 : sum_next;
        if (state_reg == PH_SETUP) begin
          if (word_cnt_reg == W_MARKER) marker_seen_reg <= (word_reg == MARKER_WORD);
          if (word_cnt_reg == W_CFG3) cfg_shadow_reg.ref_lin <= word_reg;
          if (word_cnt_reg == W_CFG4) cfg_shadow_reg.coarse_gain <= word_reg;
          if (word_cnt_reg == W_CFG5) cfg_shadow_reg.fe_limits <= word_reg;
          if (word_cnt_reg == W_CFG6) cfg_shadow_reg.temp_ctrl <= word_reg;
        end
      end
    end
  end

  // Table walk and accumulators
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      slot_reg <= SLOT_INDEX;
      entry_cnt_reg <= 5'd0;
      idx_reg <= 16'h0000;
      zslope_reg <= 16'h0000;
      prev_idx_reg <= 16'h0000;
      found_reg <= 1'b0;
      zacc_reg <= 40'sd0;
      gacc_reg <= 40'sd0;
    end else if (ce_i) begin
      if (state_reg != PH_TABLE) begin
        slot_reg <= SLOT_INDEX;
        entry_cnt_reg <= 5'd0;
        found_reg <= 1'b0;
      end else if (word_vld_reg) begin
        case (slot_reg)
          SLOT_INDEX: begin
            idx_reg <= word_reg;
            slot_reg <= SLOT_ZERO;
          end
          SLOT_ZERO: begin
            zslope_reg <= word_reg;
            slot_reg <= SLOT_GAIN;
          end
          default: begin
            slot_reg <= SLOT_INDEX;
            if (idx_reg != TABLE_END_INDEX) begin
              entry_cnt_reg <= entry_cnt_reg + 5'd1;
              prev_idx_reg <= idx_reg;
              if (entry_cnt_reg == 5'd0) begin
                zacc_reg <= $signed({16'h0000, zslope_reg, 8'h00});
                gacc_reg <= $signed({16'h0000, word_reg, 8'h00});
                found_reg <= idx_above || (idx_reg == reading_reg);
              end else if (!found_reg) begin
                zacc_reg <= zacc_reg + 40'(zprod);
                gacc_reg <= gacc_reg + 40'(gprod);
                found_reg <= idx_above;
              end
            end
          end
        endcase
      end
    end
  end

  // Scale removal with clamp to the DAC range
  function automatic logic [15:0] dac_of(input logic signed [39:0] acc);
    if (acc < 0) begin
      return 16'h0000;
    end else if (|acc[39:24]) begin
      return 16'hffff;
    end else begin
      return acc[23:8];
    end
  endfunction

  // Commit results and errors
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cfg_reg <= '{CFG_RESET, CFG_RESET, CFG_RESET, CFG_RESET};
      zero_dac_reg <= DAC_RESET;
      gain_dac_reg <= DAC_RESET;
      err_pass_reg <= '0;
      err_reg <= '0;
      error_reg <= 1'b0;
      update_reg <= 1'b0;
    end else if (ce_i) begin
      update_reg <= 1'b0;
      if (start) err_pass_reg <= '0;
      if (setup_end) begin
        if (setup_ok) cfg_reg <= cfg_shadow_reg;
        err_pass_reg.marker_bad <= !marker_seen_reg;
        err_pass_reg.setup_cs_bad <= (sum_next != CHECKSUM_TARGET);
      end
      if (term_end) begin
        if (sum_next == CHECKSUM_TARGET) begin
          zero_dac_reg <= dac_of(zacc_reg);
          gain_dac_reg <= dac_of(gacc_reg);
          update_reg <= 1'b1;
        end else begin
          err_pass_reg.table_cs_bad <= 1'b1;
        end
      end
      if (overrun) err_pass_reg.table_overrun <= 1'b1;
      if (state_reg == PH_DONE) begin
        err_reg <= err_pass_reg;
        error_reg <= |err_pass_reg;
      end
    end
  end

  assign rd_req_o = rd_req_reg;
  assign cfg_o = cfg_reg;
  assign zero_dac_o = zero_dac_reg;
  assign gain_dac_o = gain_dac_reg;
  assign load_err_o = err_reg;
  assign error_o = error_reg;
  assign busy_o = busy_reg;
  assign update_o = update_reg;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  sequence setup_good_s;
    ce_i && setup_end && setup_ok;
  endsequence
  sequence setup_bad_s;
    ce_i && setup_end && !setup_ok;
  endsequence
  sequence table_bad_s;
    ce_i && term_end && (sum_next != CHECKSUM_TARGET);
  endsequence

  a_cfg_load_setup: assert property (setup_good_s |=> cfg_reg == $past(cfg_shadow_reg))
    else $error("config not loaded at setup end");
  a_cfg_hold_bad: assert property (setup_bad_s |=> $stable(cfg_reg) ##1 $stable(cfg_reg))
    else $error("config changed after bad setup");
  a_setup_err_flag: assert property (setup_bad_s ##1 ce_i |=> ce_i |=> error_o)
    else $error("bad setup not flagged");
  a_conv_starts_read: assert property (ce_i && conv_done_i && state_reg == PH_IDLE |=> rd_req_o)
    else $error("conversion did not start a read");
  a_conv_pending: assert property (ce_i && conv_done_i && state_reg != PH_IDLE |=> pend_reg)
    else $error("conversion during pass lost");
  a_dac_hold_bad: assert property (table_bad_s |=> $stable(gain_dac_reg) && $stable(zero_dac_reg))
    else $error("DAC changed on bad table checksum");
  a_word_pairing: assert property (byte_done && odd_byte_reg && state_reg != PH_IDLE
      |=> word_vld_reg && word_reg[15:8] == $past(high_byte_reg))
    else $error("word assembled out of order");
  a_start_accum: assert property (ce_i && word_vld_reg && state_reg == PH_TABLE && slot_reg == SLOT_GAIN
      && entry_cnt_reg == 5'd0 && idx_reg != TABLE_END_INDEX |=> gacc_reg[23:8] == $past(word_reg))
    else $error("gain accumulator not seeded");
  a_found_freeze: assert property (found_reg && state_reg == PH_TABLE && slot_reg == SLOT_GAIN
      && entry_cnt_reg != 5'd0 |=> $stable(gacc_reg))
    else $error("accumulator moved after interpolation found");
  a_read_to_end: assert property (ce_i && found_reg && state_reg == PH_TABLE && !term_end && !overrun
      |=> state_reg == PH_TABLE)
    else $error("read stopped before terminator");

endmodule // eeprom_calib_lookup_interp

// File: bench/eeprom_model.sv
// Serial calibration memory model: streams words MSB first while the read request is high.
// Assumes the bench fills mem between passes; the link clock stands still outside a pass.
`timescale 1ns/1ps
module eeprom_model (
  input wire logic rd_req_i,
  output logic link_clk_o,
  output logic link_data_o
);
  logic [15:0] mem [0:63];
  int pass_n = 0;
  int p = 0;
  int bit_n;

  initial begin
    link_clk_o = 1'b0;
    link_data_o = 1'b0;
  end

  always @(posedge rd_req_i) pass_n++;

  // Restart from byte 0 on every new request, even after a short gap
  always begin
    wait (rd_req_i === 1'b1 && p != pass_n);
    p = pass_n;
    bit_n = 0;
    while (rd_req_i === 1'b1 && p == pass_n && bit_n < 1024) begin
      link_data_o = mem[bit_n / 16][15 - bit_n % 16];
      #20;
      if (rd_req_i === 1'b1 && p == pass_n) link_clk_o = 1'b1;
      #40 link_clk_o = 1'b0;
      #20 bit_n++;
    end
    // Released line shows the inverse, not a stale bit
    link_data_o = ~link_data_o;
  end
endmodule // eeprom_model

// File: bench/tb_eeprom_calib_lookup_interp.sv
// Self-checking bench for the calibration loader and interpolation engine.
// Assumes eeprom_model as the memory; the design's own assertions guard the timing.
`timescale 1ns/1ps
module tb_eeprom_calib_lookup_interp;
  import eeprom_calib_pkg::*;
  localparam logic [15:0] MARK = 16'ha5c3; // Arbitrary marker, as the design default
  localparam logic [383:0] TAB5 = {48'hfd80_051f_ffff, 48'hfe20_0830_c292, 48'hfec0_418a_851e,
    48'hff60_0000_47ae, 48'h0000_51eb_d70a, 48'h00a0_d70b_a3d6, 48'h0140_d70a_b392, 48'h01e0_51eb_6dcb};
  localparam logic [383:0] UTAB = {48'h1000_2000_8000, 48'h9000_0100_0080, 48'hc000_ff00_ff80, 240'h0};
  typedef struct packed {
    cfg_regs_s cfg;
    logic [15:0] zero;
    logic [15:0] gain;
  } exp_s;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ce_i = 1'b1;
  logic conv_done_i = 1'b0;
  logic [15:0] conv_result_i = 16'h0000;
  logic link_clk;
  logic link_data;
  logic rd_req;
  cfg_regs_s cfg;
  logic [15:0] zero_dac;
  logic [15:0] gain_dac;
  load_err_s load_err;
  logic error_flag;
  logic busy;
  logic update;
  int error_cnt = 0;
  int tests_run = 0;
  logic [31:0] lfsr_reg = 32'h0000_01f3;
  logic [15:0] m [0:63];
  logic [15:0] tt [0:16];
  logic [15:0] zz [0:16];
  logic [15:0] gg [0:16];
  logic [15:0] rds [5] = '{16'hfc00, 16'hfd80, 16'hfe20, 16'hfe00, 16'h0100};
  int n_ent;
  logic uns;
  cfg_regs_s cur_cfg;
  exp_s exp_q [$];
  exp_s got_e;
  exp_s last_e;

  always #2.5 clk_sys_i = ~clk_sys_i;

  eeprom_calib_lookup_interp dut_u (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .conv_done_i(conv_done_i),
    .conv_result_i(conv_result_i), .link_clk_i(link_clk), .link_data_i(link_data), .rd_req_o(rd_req),
    .cfg_o(cfg), .zero_dac_o(zero_dac), .gain_dac_o(gain_dac), .load_err_o(load_err),
    .error_o(error_flag), .busy_o(busy), .update_o(update)
  );

  eeprom_model model_u (.rd_req_i(rd_req), .link_clk_o(link_clk), .link_data_o(link_data));

  function automatic logic [15:0] rnd();
    lfsr_reg = {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
    return lfsr_reg[15:0];
  endfunction

  task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  function automatic longint kv(input logic [15:0] x);
    return uns ? longint'(x) : longint'($signed(x));
  endfunction

  function automatic logic [15:0] interp(input logic [15:0] rd, input logic gsel);
    longint acc;
    longint sl;
    logic found;
    acc = longint'(gsel ? gg[0] : zz[0]) <<< 8;
    found = kv(rd) <= kv(tt[0]);
    for (int i = 1; i < n_ent; i++) begin
      sl = longint'($signed(gsel ? gg[i] : zz[i]));
      if (!found && kv(tt[i]) > kv(rd)) begin
        acc += sl * (kv(rd) - kv(tt[i - 1]));
        found = 1'b1;
      end else if (!found) begin
        acc += sl * (kv(tt[i]) - kv(tt[i - 1]));
      end
    end
    acc = acc >>> 8;
    return acc < 0 ? 16'h0000 : acc > 65535 ? 16'hffff : acc[15:0];
  endfunction

  task automatic set_tab(input logic [383:0] src, input int n, input logic u);
    n_ent = n;
    uns = u;
    for (int e = 0; e < n; e++) {tt[e], zz[e], gg[e]} = src[383 - 48 * e -: 48];
  endtask

  // Bad bits: marker, setup checksum, table checksum
  task automatic load_mem(input logic [2:0] bad);
    logic [15:0] s;
    int w;
    cur_cfg = {rnd(), rnd(), rnd(), rnd()};
    cur_cfg.temp_ctrl[CFG6_UNSIGNED_BIT] = uns;
    m[0] = bad[2] ? ~MARK : MARK;
    m[1] = rnd();
    m[2] = rnd();
    {m[3], m[4], m[5], m[6]} = cur_cfg;
    s = 16'h0000;
    for (int i = 0; i < 7; i++) s += m[i];
    m[7] = CHECKSUM_TARGET - s + {15'h0, bad[1]};
    s = 16'h0000;
    w = 8;
    for (int e = 0; e < n_ent; e++) begin
      {m[w], m[w + 1], m[w + 2]} = {tt[e], zz[e], gg[e]};
      s += tt[e] + zz[e] + gg[e];
      w += 3;
    end
    m[w] = TABLE_END_INDEX;
    m[w + 1] = rnd();
    m[w + 2] = CHECKSUM_TARGET - s - m[w] - m[w + 1] + {15'h0, bad[0]};
    model_u.mem = m;
  endtask

  task automatic conv(input logic [15:0] rd, input logic upd);
    @(posedge clk_sys_i);
    #1;
    conv_done_i = 1'b1;
    conv_result_i = rd;
    if (upd) begin
      last_e = {cur_cfg, interp(rd, 1'b0), interp(rd, 1'b1)};
      exp_q.push_back(last_e);
    end
    @(posedge clk_sys_i);
    #1;
    conv_done_i = 1'b0;
    conv_result_i = rnd();
    chk({95'h0, busy}, 96'h1, "busy after conversion");
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    repeat (4) @(posedge clk_sys_i);
    while ((busy !== 1'b0 || exp_q.size() != 0) && k < 30000) begin
      @(posedge clk_sys_i);
      k++;
    end
    repeat (3) @(posedge clk_sys_i);
    if (k >= 30000) chk(96'h1, 96'h0, "pass never finished");
  endtask

  task automatic check_err(input logic [3:0] e);
    chk({91'h0, error_flag, load_err}, {91'h0, |e, e}, "error flags");
  endtask

  task automatic run(input logic [15:0] rd, input logic [2:0] bad);
    exp_s keep;
    keep = last_e;
    load_mem(bad);
    conv(rd, bad == 3'b000);
    wait_idle();
    check_err({bad, 1'b0});
    if (bad != 3'b000) chk({cfg, zero_dac, gain_dac}, {bad[0] ? cur_cfg : keep.cfg, keep.zero, keep.gain},
      "outputs after bad load");
  endtask

  // Compare each DAC update with the oldest expectation
  always @(posedge clk_sys_i) begin
    #1;
    if (update === 1'b1) begin
      if (exp_q.size() == 0) chk(96'h1, 96'h0, "update with nothing expected");
      else begin
        got_e = exp_q.pop_front();
        chk({cfg, zero_dac, gain_dac}, got_e, "config and DAC outputs");
      end
    end
  end

  task automatic finish_test();
    $display("Checks %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #450_000;
    chk(96'h1, 96'h0, "watchdog expired");
    finish_test();
  end

  initial begin
    repeat (10) @(posedge clk_sys_i);
    #1;
    chk({cfg, zero_dac, gain_dac}, 96'h0, "outputs in reset");
    check_err(4'h0);
    rst_b_i = 1'b1;
    set_tab(TAB5, 8, 1'b0);
    run(16'h0190, 3'b000);
    set_tab(TAB5, 3, 1'b0);
    foreach (rds[i]) run(rds[i], 3'b000);
    run(rnd(), 3'b000);
    load_mem(3'b000);
    conv(16'hfe00, 1'b1);
    repeat (50) @(posedge clk_sys_i);
    conv(rnd(), 1'b0);
    conv(16'hfd90, 1'b1);
    wait_idle();
    set_tab(UTAB, 3, 1'b1);
    run(16'ha000, 3'b000);
    run(16'ha000, 3'b100);
    run(16'h0010, 3'b010);
    run(16'h0010, 3'b001);
    run(16'hb000, 3'b000);
    finish_test();
  end
endmodule // tb_eeprom_calib_lookup_interp
